/* File: logic/mcmsi_top.sv */
// mode strap, switch debounce, analog mux scan, serial link and ahb registers
`timescale 1ns/1ns
`include "mcmsi_defines.svh"
// Behaviour
// - A high strap level seen after reset selects standalone operation.
// - A low strap level seen in the init phase selects hosted serial operation.
// - Standalone setup comes from the external resistor network, not from a host.
// - Standalone drives the select line of each parameter while watching its inputs.
// - A parameter is read by pulling its select line low and sampling the shared input.
// - Speed, pwm rate, bus voltage and acceleration are rescanned until the fifo is full; the scan then waits for a fifo read.
// - The start input is debounced and level sensitive.
// - A low start level counts only after a high level has been seen there.
// - The direction input is debounced and level sensitive.
// - Hosted traffic runs on an asynchronous link at 9600 baud.
// - In hosted operation control comes only from the serial port.
// - In hosted operation the local pins do not steer the motor.
// - In hosted operation the input states stay readable.
// - Pwm outputs float while the supply monitor reports low supply.
module mcmsi_top
  import mcmsi_pkg::*;
#(
  parameter int DEB_CYC = `MCMSI_DEB_CYC,
  parameter int BAUD_DIV = `MCMSI_BAUD_DIV,
  parameter int NCHAN = `MCMSI_NCHAN,
  parameter int FIFO_DEPTH = `MCMSI_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mode_strap_in,
  input wire logic start_in,
  input wire logic direction_in,
  input wire logic [1:0] polarity_basefreq_sel_in,
  input wire logic supply_low_in,
  input wire logic uart_rx_in,
  output logic uart_tx_out,
  output logic [NCHAN-1:0] param_sel_n_out,
  output logic adc_start_out,
  input wire logic adc_valid_in,
  input wire logic [9:0] adc_data_in,
  output logic motor_run_out,
  output logic motor_fwd_out,
  output logic pwm_oe_out,
  output logic standalone_out
);
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int BW = $clog2(BAUD_DIV + 1);
  localparam int SW = $clog2(`MCMSI_SETTLE_CYC + 1);
  localparam int IW = $clog2(`MCMSI_INIT_CYC + 1);
  if (DEB_CYC < 2 || BAUD_DIV < 16 || NCHAN < 2 || NCHAN > 4)
  begin : g_bad
    $error("unsupported debounce, baud or channel parameter");
  end

  // one-hot low select pattern for a channel
  function automatic logic [NCHAN-1:0] chan_sel_n(input logic [1:0] ch);
    chan_sel_n = ~(NCHAN'(1) << ch);
  endfunction

  logic [6:0] pin_m_r;
  logic [6:0] pin_s_r;
  logic [IW-1:0] init_cnt_r;
  logic mode_valid_r;
  logic [1:0] pol_r;
  logic [1:0] deb_in;
  logic [1:0] filt_r;
  logic [DW-1:0] deb_cnt_r [2];
  logic start_armed_r;
  logic [7:0] host_r;
  mcmsi_scan_t scan_st_r;
  logic [1:0] chan_r;
  logic [SW-1:0] settle_r;
  mcmsi_sample_t sample_r;
  logic config_done_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  mcmsi_sample_t fifo_out_data;
  logic fifo_pop;
  logic ctrl_mon_r;
  mcmsi_aphase_t wph_r;
  logic ahb_req;
  logic [31:0] rd_val;
  logic tx_go;
  logic tx_busy_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic [BW-1:0] tx_cnt_r;
  logic rx_busy_r;
  logic [3:0] rx_bit_r;
  logic [BW-1:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic rx_done_r;
  logic rx_valid_r;
  logic rd_uart;

  // every strap, switch, supply and rx pin crosses two flops before use; rx idles high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_m_r <= `MCMSI_PIN_RST;
      pin_s_r <= `MCMSI_PIN_RST;
    end
    else
    begin
      pin_m_r <= {polarity_basefreq_sel_in, uart_rx_in, supply_low_in,
                  direction_in, start_in, mode_strap_in};
      pin_s_r <= pin_m_r;
    end
  end

  // strap and jumper caught once, after the init wait lets the synchroniser fill
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      init_cnt_r <= '0;
      mode_valid_r <= 1'b0;
      standalone_out <= 1'b0;
      pol_r <= 2'h0;
    end
    else if (!mode_valid_r)
    begin
      init_cnt_r <= init_cnt_r + 1'b1;
      if (init_cnt_r == IW'(`MCMSI_INIT_CYC - 1))
      begin
        mode_valid_r <= 1'b1;
        standalone_out <= pin_s_r[`MCMSI_PIN_MODE];
        pol_r <= pin_s_r[`MCMSI_PIN_POL +: 2];
      end
    end
  end

  // debounce: level moves only after DEB_CYC equal samples in a row
  assign deb_in = {pin_s_r[`MCMSI_PIN_DIR], pin_s_r[`MCMSI_PIN_START]};
  for (genvar i = 0; i < 2; i++)
  begin : g_deb
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        deb_cnt_r[i] <= '0;
        filt_r[i] <= 1'b0;
      end
      else if (deb_in[i] == filt_r[i])
        deb_cnt_r[i] <= '0;
      else if (deb_cnt_r[i] == DW'(DEB_CYC - 1))
      begin
        filt_r[i] <= deb_in[i];
        deb_cnt_r[i] <= '0;
      end
      else
        deb_cnt_r[i] <= deb_cnt_r[i] + 1'b1;
    end
  end

  // a switch held in start at power-up never arms, so no surprise start
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      start_armed_r <= 1'b0;
    else if (filt_r[0])
      start_armed_r <= 1'b1;
  end

  // motor commands: local pins standalone, serial bytes hosted
  always_ff @(posedge clk)
  begin
    if (!rst_n || !mode_valid_r)
    begin
      motor_run_out <= 1'b0;
      motor_fwd_out <= 1'b0;
    end
    else if (standalone_out)
    begin
      motor_run_out <= start_armed_r & ~filt_r[0];
      motor_fwd_out <= filt_r[1];
    end
    else
    begin
      motor_run_out <= host_r[`MCMSI_HOST_RUN];
      motor_fwd_out <= host_r[`MCMSI_HOST_FWD];
    end
  end

  // pwm drivers released while the supply monitor flags low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pwm_oe_out <= 1'b0;
    else
      pwm_oe_out <= ~pin_s_r[`MCMSI_PIN_SUP];
  end

  // mux scan; hosted mode scans only when software asks for monitoring
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scan_st_r <= SC_IDLE;
      chan_r <= 2'h0;
      settle_r <= '0;
      sample_r <= '0;
      config_done_r <= 1'b0;
      param_sel_n_out <= '1;
      adc_start_out <= 1'b0;
    end
    else
    begin
      case (scan_st_r)
        SC_IDLE:
        begin
          if (mode_valid_r && (standalone_out || ctrl_mon_r))
          begin
            param_sel_n_out <= chan_sel_n(chan_r);
            settle_r <= '0;
            scan_st_r <= SC_DRIVE;
          end
        end
        SC_DRIVE:
        begin
          // let the outside mux and network settle before converting
          if (settle_r == SW'(`MCMSI_SETTLE_CYC - 1))
          begin
            adc_start_out <= 1'b1;
            scan_st_r <= SC_CONV;
          end
          else
            settle_r <= settle_r + 1'b1;
        end
        SC_CONV:
        begin
          adc_start_out <= 1'b0;
          if (adc_valid_in)
          begin
            sample_r <= '{chan: chan_r, value: adc_data_in};
            scan_st_r <= SC_PUSH;
          end
        end
        SC_PUSH:
        begin
          // a full fifo holds the scan here, nothing is dropped
          if (fifo_in_ready)
          begin
            param_sel_n_out <= '1;
            chan_r <= (chan_r == 2'(NCHAN - 1)) ? 2'h0 : chan_r + 1'b1;
            if (chan_r == 2'(NCHAN - 1))
              config_done_r <= 1'b1;
            scan_st_r <= SC_IDLE;
          end
        end
        default: scan_st_r <= SC_IDLE;
      endcase
    end
  end

  mcmsi_fifo #(
    .WIDTH($bits(mcmsi_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(scan_st_r == SC_PUSH),
    .in_data(sample_r),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  // bus decode; reads act in the address phase, writes in the data phase
  assign ahb_req = hsel & htrans[1] & hready;
  assign fifo_pop = ahb_req & ~hwrite & (haddr[11:0] == `MCMSI_OFF_FIFO);
  assign rd_uart = ahb_req & ~hwrite & (haddr[11:0] == `MCMSI_OFF_UART);
  assign tx_go = wph_r.valid & (wph_r.addr == `MCMSI_OFF_UART) & ~tx_busy_r;

  always_comb
  begin
    case (haddr[11:0])
      `MCMSI_OFF_CTRL: rd_val = {31'h0, ctrl_mon_r};
      `MCMSI_OFF_STAT: rd_val = {19'h0, pol_r, fifo_out_valid, rx_valid_r, tx_busy_r,
                                 motor_fwd_out, motor_run_out, start_armed_r, filt_r,
                                 config_done_r, standalone_out, mode_valid_r};
      // an empty fifo reads as zero rather than stale storage
      `MCMSI_OFF_FIFO: rd_val = {19'h0, fifo_out_valid, fifo_out_valid ? fifo_out_data : 12'h0};
      `MCMSI_OFF_UART: rd_val = {23'h0, rx_valid_r, rx_byte_r};
      default: rd_val = 32'h0;
    endcase
  end

  // zero wait state slave, always okay
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wph_r <= '0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_mon_r <= `MCMSI_CTRL_RST;
    end
    else
    begin
      wph_r <= '{valid: ahb_req & hwrite, addr: haddr[11:0]};
      hrdata <= (ahb_req && !hwrite) ? rd_val : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (wph_r.valid && wph_r.addr == `MCMSI_OFF_CTRL)
        ctrl_mon_r <= hwdata[`MCMSI_CTRL_MON];
    end
  end

  // serial transmit: start, eight data bits lsb first, stop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 9'h1ff;
      tx_bit_r <= 4'h0;
      tx_cnt_r <= '0;
      uart_tx_out <= 1'b1;
    end
    else if (tx_go)
    begin
      tx_busy_r <= 1'b1;
      tx_sh_r <= {1'b1, hwdata[7:0]};
      tx_bit_r <= 4'h0;
      tx_cnt_r <= '0;
      uart_tx_out <= 1'b0;
    end
    else if (tx_busy_r)
    begin
      if (tx_cnt_r == BW'(BAUD_DIV - 1))
      begin
        tx_cnt_r <= '0;
        tx_bit_r <= tx_bit_r + 1'b1;
        if (tx_bit_r == 4'h9)
          tx_busy_r <= 1'b0;
        else
        begin
          uart_tx_out <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[8:1]};
        end
      end
      else
        tx_cnt_r <= tx_cnt_r + 1'b1;
    end
  end

  // serial receive, sampled mid bit; a bad stop bit drops the byte
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_busy_r <= 1'b0;
      rx_bit_r <= 4'h0;
      rx_cnt_r <= '0;
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_done_r <= 1'b0;
      host_r <= 8'h00;
    end
    else
    begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r)
      begin
        rx_busy_r <= ~pin_s_r[`MCMSI_PIN_RX];
        rx_bit_r <= 4'h0;
        rx_cnt_r <= '0;
      end
      else if (rx_cnt_r == ((rx_bit_r == 4'h0) ? BW'(BAUD_DIV / 2 - 1) : BW'(BAUD_DIV - 1)))
      begin
        rx_cnt_r <= '0;
        rx_bit_r <= rx_bit_r + 1'b1;
        if (rx_bit_r == 4'h0)
          rx_busy_r <= ~pin_s_r[`MCMSI_PIN_RX];
        else if (rx_bit_r != 4'h9)
          rx_sh_r <= {pin_s_r[`MCMSI_PIN_RX], rx_sh_r[7:1]};
        else
        begin
          rx_busy_r <= 1'b0;
          if (pin_s_r[`MCMSI_PIN_RX])
          begin
            rx_done_r <= 1'b1;
            rx_byte_r <= rx_sh_r;
            if (mode_valid_r && !standalone_out)
              host_r <= rx_sh_r;
          end
        end
      end
      else
        rx_cnt_r <= rx_cnt_r + 1'b1;
    end
  end

  // received flag; a new byte wins over a clearing read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_valid_r <= 1'b0;
    else
      rx_valid_r <= rx_done_r | (rx_valid_r & ~rd_uart);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_strap_mode: assert property ($rose(mode_valid_r) |->
    standalone_out == $past(pin_s_r[`MCMSI_PIN_MODE])) else $error("mode not from strap");
  chk_start_arm: assert property (standalone_out && !start_armed_r |=>
    !motor_run_out) else $error("run before start was armed");
  chk_deb_count: assert property ($changed(filt_r[0]) |->
    $past(deb_cnt_r[0]) == DW'(DEB_CYC - 1)) else $error("start filter moved early");
  chk_fwd_follow: assert property (mode_valid_r && standalone_out |=>
    motor_fwd_out == $past(filt_r[1])) else $error("direction not from filter");
  chk_hosted_ctrl: assert property (mode_valid_r && !standalone_out |=>
    motor_run_out == $past(host_r[`MCMSI_HOST_RUN])) else $error("hosted run not serial");
  chk_pwm_float: assert property (pin_s_r[`MCMSI_PIN_SUP] |=>
    !pwm_oe_out) else $error("pwm driven at low supply");
  chk_sel_conv: assert property (scan_st_r == SC_CONV |->
    param_sel_n_out == chan_sel_n(chan_r)) else $error("select not low in conversion");
  chk_settle_wait: assert property ($rose(scan_st_r == SC_DRIVE) |->
    !adc_start_out [*8]) else $error("conversion before settle");
  chk_push_stall: assert property (scan_st_r == SC_PUSH && !fifo_in_ready |=>
    scan_st_r == SC_PUSH) else $error("sample lost on full fifo");
  chk_tx_start: assert property (tx_go |=> !uart_tx_out ##1
    !uart_tx_out) else $error("start bit missing");

  cov_config: cover property ($rose(config_done_r));
  cov_start: cover property ($rose(motor_run_out) && standalone_out);
  cov_rx_byte: cover property (rx_done_r && !standalone_out);
  cov_fifo_full: cover property (scan_st_r == SC_PUSH && !fifo_in_ready);
endmodule

/* File: logic/mcmsi_defines.svh */
// constants for the motor control mode select front end
`ifndef MCMSI_DEFINES_SVH
`define MCMSI_DEFINES_SVH
`define MCMSI_CLK_HZ 250000000
`define MCMSI_CLK_PERIOD_NS 4
`define MCMSI_BAUD 9600
`define MCMSI_BAUD_DIV (`MCMSI_CLK_HZ / `MCMSI_BAUD)
`define MCMSI_DEB_TIME_US 1000
`define MCMSI_DEB_CYC (`MCMSI_DEB_TIME_US * (`MCMSI_CLK_HZ / 1000000))
`define MCMSI_SETTLE_TIME_NS 2000
`define MCMSI_SETTLE_CYC \
  ((`MCMSI_SETTLE_TIME_NS + `MCMSI_CLK_PERIOD_NS - 1) / `MCMSI_CLK_PERIOD_NS)
`define MCMSI_INIT_CYC 16
`define MCMSI_NCHAN 4
`define MCMSI_FIFO_DEPTH 4
`define MCMSI_ADC_W 10
`define MCMSI_OFF_CTRL 12'h000
`define MCMSI_OFF_STAT 12'h004
`define MCMSI_OFF_FIFO 12'h008
`define MCMSI_OFF_UART 12'h00c
`define MCMSI_CTRL_MON 0
`define MCMSI_CTRL_RST 1'h0
`define MCMSI_HOST_RUN 0
`define MCMSI_HOST_FWD 1
`define MCMSI_PIN_MODE 0
`define MCMSI_PIN_START 1
`define MCMSI_PIN_DIR 2
`define MCMSI_PIN_SUP 3
`define MCMSI_PIN_RX 4
`define MCMSI_PIN_POL 5
`define MCMSI_PIN_RST 7'h10
`endif

/* File: logic/mcmsi_pkg.sv */
// types shared by the mode select front end
package mcmsi_pkg;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_DRIVE = 2'b01,
    SC_CONV = 2'b10,
    SC_PUSH = 2'b11
  } mcmsi_scan_t;
  typedef struct packed {
    logic [1:0] chan;
    logic [9:0] value;
  } mcmsi_sample_t;
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
  } mcmsi_aphase_t;
endpackage

/* File: logic/mcmsi_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module mcmsi_fifo
  import mcmsi_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset, only pointers and the fill count do
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

/* File: dv/mcmsi_mux_model.sv */
// model of the external analog mux and converter behind the scan port
`timescale 1ns/1ns
module mcmsi_mux_model
(
  input wire logic clk,
  input wire logic [3:0] sel_n,
  input wire logic conv,
  output logic done,
  output logic [9:0] data
);
  int wait_cnt = -1;
  logic slow = 1'b0;
  logic [1:0] ch;
  // one driver per output; the start value keeps the wandering input known
  logic done_r = 1'b0;
  logic [9:0] data_r = 10'h155;
  assign done = done_r;
  assign data = data_r;
  // routed channel is the low select line
  always_comb
  begin
    ch = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (!sel_n[i]) ch = i[1:0];
  end
  // answers alternate prompt and slow; the idle input wanders so stale data cannot pass
  always @(posedge clk)
  begin
    done_r <= 1'b0;
    data_r <= ~data_r;
    if (conv)
    begin
      wait_cnt <= slow ? 20 : 1;
      slow <= ~slow;
    end
    else if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    else if (wait_cnt == 0)
    begin
      wait_cnt <= -1;
      done_r <= 1'b1;
      data_r <= (sel_n == 4'hf) ? ~data_r : {ch, 8'h3c};
    end
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking testbench for the mode select front end
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, uart_tx_out, adc_start_out, adc_valid_in;
  logic motor_run_out, motor_fwd_out, pwm_oe_out, standalone_out;
  logic [3:0] param_sel_n_out;
  logic [9:0] adc_data_in;
  logic mode_strap_in = 1'b1;
  logic start_in = 1'b0;
  logic direction_in = 1'b0;
  // a single jumper fitted on the selector
  logic [1:0] polarity_basefreq_sel_in = 2'h2;
  logic supply_low_in = 1'b0;
  logic uart_rx_in = 1'b1;
  logic [31:0] rd;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  // short debounce and bit time keep the run brief
  mcmsi_top #(.DEB_CYC(8), .BAUD_DIV(16)) u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_strap_in(mode_strap_in), .start_in(start_in), .direction_in(direction_in),
    .polarity_basefreq_sel_in(polarity_basefreq_sel_in), .supply_low_in(supply_low_in),
    .uart_rx_in(uart_rx_in), .uart_tx_out(uart_tx_out), .param_sel_n_out(param_sel_n_out),
    .adc_start_out(adc_start_out), .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in),
    .motor_run_out(motor_run_out), .motor_fwd_out(motor_fwd_out), .pwm_oe_out(pwm_oe_out),
    .standalone_out(standalone_out));
  mcmsi_mux_model u_mux (.clk(clk), .sel_n(param_sel_n_out), .conv(adc_start_out),
    .done(adc_valid_in), .data(adc_data_in));
  task automatic results();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // single ahb transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic do_reset(input logic strap, input logic st);
    rst_n <= 1'b0;
    mode_strap_in <= strap;
    start_in <= st;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (24) @(posedge clk);
  endtask
  // fill the fifo until the scan stalls, then drain it in channel order
  task automatic t_scan();
    repeat (2700) @(posedge clk);
    chk(param_sel_n_out, 4'he);
    for (int c = 0; c < 4; c++)
    begin
      ahb(1'b0, 12'h008, 32'h0, rd);
      chk(rd, {19'h0, 1'b1, c[1:0], c[1:0], 8'h3c});
    end
    ahb(1'b0, 12'h004, 32'h0, rd);
    chk(rd & 32'h1807, 32'h1007);
    chk(standalone_out, 1'b1);
    ahb(1'b0, 12'h010, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 12'h000, 32'h1, rd);
    ahb(1'b0, 12'h000, 32'h0, rd);
    chk(rd, 32'h1);
  endtask
  // switch held low at power-up, then arm, start and direction with a glitch
  task automatic t_switch();
    chk(motor_run_out, 1'b0);
    start_in <= 1'b1;
    repeat (20) @(posedge clk);
    start_in <= 1'b0;
    repeat (5) @(posedge clk);
    chk(motor_run_out, 1'b0);
    repeat (15) @(posedge clk);
    chk(motor_run_out, 1'b1);
    direction_in <= 1'b1;
    repeat (20) @(posedge clk);
    direction_in <= 1'b0;
    repeat (3) @(posedge clk);
    direction_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk(motor_fwd_out, 1'b1);
    repeat (12) @(posedge clk);
    chk(motor_fwd_out, 1'b1);
    chk(pwm_oe_out, 1'b1);
    supply_low_in <= 1'b1;
    repeat (5) @(posedge clk);
    chk(pwm_oe_out, 1'b0);
    supply_low_in <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] bits;
    bits = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      uart_rx_in <= bits[i];
      repeat (16) @(posedge clk);
    end
  endtask
  // hosted: pins ignored but readable, serial byte steers, serial send framed
  task automatic t_hosted();
    logic [7:0] got;
    ahb(1'b0, 12'h004, 32'h0, rd);
    chk(rd & 32'h3, 32'h1);
    chk(standalone_out, 1'b0);
    start_in <= 1'b1;
    repeat (20) @(posedge clk);
    start_in <= 1'b0;
    direction_in <= 1'b1;
    repeat (20) @(posedge clk);
    chk({motor_run_out, motor_fwd_out, param_sel_n_out}, 6'h0f);
    ahb(1'b0, 12'h004, 32'h0, rd);
    chk(rd & 32'h38, 32'h30);
    chk({hreadyout, hresp}, 2'h2);
    ahb(1'b0, 12'h008, 32'h0, rd);
    chk(rd, 32'h0);
    uart_send(8'h03);
    repeat (4) @(posedge clk);
    ahb(1'b0, 12'h00c, 32'h0, rd);
    chk(rd & 32'h1ff, 32'h103);
    chk({motor_run_out, motor_fwd_out}, 2'h3);
    ahb(1'b0, 12'h00c, 32'h0, rd);
    chk(rd & 32'h100, 32'h0);
    ahb(1'b1, 12'h00c, 32'h5a, rd);
    for (int n = 0; n < 50 && uart_tx_out !== 1'b0; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(uart_tx_out, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge clk);
      got[i] = uart_tx_out;
    end
    chk(got, 8'h5a);
    repeat (16) @(posedge clk);
    chk(uart_tx_out, 1'b1);
    // monitoring in hosted mode still scans the mux
    ahb(1'b1, 12'h000, 32'h1, rd);
    repeat (3) @(posedge clk);
    chk(param_sel_n_out, 4'he);
  endtask
  initial
  begin
    do_reset(1'b1, 1'b0);
    t_switch();
    do_reset(1'b1, 1'b1);
    t_scan();
    do_reset(1'b0, 1'b0);
    t_hosted();
    results();
  end
endmodule
